// *** rtl/supply_monitor_pkg.sv ***
// Constants, types and register map of the supply voltage monitor
package supply_monitor_pkg;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS         = 8'h1C;
  localparam logic [7:0]  FLAGS_OFS        = 8'h20;

  // Reset values
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0004;
  localparam logic [31:0] FLAGS_RESET      = 32'h0000_0000;

  // Field positions of detector_control
  localparam int          DROOP_EN_BIT     = 0;
  localparam int          RECOV_EN_BIT     = 1;
  localparam int          POWER_DOWN_BIT   = 2;
  localparam int          DELAY_LSB        = 3;
  localparam int          THRESH_LSB       = 5;

  // Field positions of detector_event_flags
  localparam int          DROOP_FLAG_BIT   = 0;
  localparam int          RECOV_FLAG_BIT   = 1;

  // Timing
  localparam int          CLK_PERIOD_NS    = 5;
  localparam int          NS_PER_US        = 1000;
  localparam int          CYC_PER_US       = NS_PER_US / CLK_PERIOD_NS;
  localparam int          COUNT_W          = 15;

  // Qualification delay in microseconds, indexed by threshold then delay code
  localparam logic [6:0]  QUAL_US [8][4] = '{
    '{7'd7,  7'd14, 7'd29, 7'd57},
    '{7'd7,  7'd14, 7'd29, 7'd57},
    '{7'd8,  7'd16, 7'd32, 7'd63},
    '{7'd9,  7'd17, 7'd34, 7'd68},
    '{7'd9,  7'd18, 7'd36, 7'd73},
    '{7'd10, 7'd19, 7'd38, 7'd77},
    '{7'd10, 7'd20, 7'd40, 7'd80},
    '{7'd16, 7'd21, 7'd42, 7'd83}
  };

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_WATCH = 2'b01,
    ST_LOW   = 2'b10
  } mon_state_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    logic        power_down;
    logic [2:0]  threshold_select;
  } analog_ctrl_s;

endpackage

// *** rtl/supply_voltage_monitor.sv ***
// Supply voltage monitor: control registers, event qualification and interrupt
`timescale 1ns/1ps
// How it works
// - Threshold codes 1..7 select 2.7 to 4.5 V; code 0 reserved.
// - Two-bit delay code picks one of four qualification delays, shortest first.
// - Qualification delay comes from threshold and delay code together.
// - Comparator indications shorter than the delay are ignored entirely.
// - Supply held below threshold for the delay sets the droop event.
// - Recovery counts only after droop, once supply passes threshold plus hysteresis.
// - Power-down bit turns detector off when 1; resets to 1.
// - Control bit 1 enables the recovery interrupt.
// - Control bit 0 enables the droop interrupt.
// - Flag bit 0 shows droop; write 1 clears, write 0 ignored.
// - Flag bit 1 shows recovery; write 1 clears, write 0 ignored.
module supply_voltage_monitor
  import supply_monitor_pkg::*;
#(
  parameter int US_CYCLES = CYC_PER_US
)(
  input  wire logic                             CORE_CLK,
  input  wire logic                             RESETN,
  input  wire supply_monitor_pkg::wb_req_s      WB_REQ,
  output supply_monitor_pkg::wb_rsp_s           WB_RSP,
  input  wire logic                             CMP_BELOW,
  input  wire logic                             CMP_ABOVE,
  output supply_monitor_pkg::analog_ctrl_s      ANA_CTRL,
  output logic                                  IRQ
);
  import supply_monitor_pkg::*;

  typedef struct packed {
    logic [2:0]         threshold_select;
    logic [1:0]         delay_select;
    logic               detector_power_down;
    logic               recovery_irq_enable;
    logic               droop_irq_enable;
    logic               droop_flag;
    logic               recovery_flag;
    logic [1:0]         sync1;
    logic [1:0]         sync2;
    mon_state_e         state;
    logic [COUNT_W-1:0] count;
    logic               ack;
    logic [31:0]        rdata;
    logic               irq;
  } mon_state_s;

  localparam mon_state_s STATE_RESET = '{
    threshold_select    : CTRL_RESET[THRESH_LSB +: 3],
    delay_select        : CTRL_RESET[DELAY_LSB +: 2],
    detector_power_down : CTRL_RESET[POWER_DOWN_BIT],
    recovery_irq_enable : CTRL_RESET[RECOV_EN_BIT],
    droop_irq_enable    : CTRL_RESET[DROOP_EN_BIT],
    droop_flag          : FLAGS_RESET[DROOP_FLAG_BIT],
    recovery_flag       : FLAGS_RESET[RECOV_FLAG_BIT],
    sync1               : 2'h0,
    sync2               : 2'h0,
    state               : ST_OFF,
    count               : '0,
    ack                 : 1'b0,
    rdata               : 32'h0000_0000,
    irq                 : 1'b0
  };

  mon_state_s st_reg;
  mon_state_s st_next;

  // Reserved code 0 falls back to the lowest row; the comparator model trips at 2.4 V for it
  function automatic logic [COUNT_W-1:0] qual_cycles(input logic [2:0] th,
                                                     input logic [1:0] dl);
    qual_cycles = COUNT_W'(int'(QUAL_US[th][dl]) * US_CYCLES);
  endfunction

  function automatic logic [31:0] ctrl_word(input mon_state_s s);
    ctrl_word                     = 32'h0000_0000;
    ctrl_word[THRESH_LSB +: 3]    = s.threshold_select;
    ctrl_word[DELAY_LSB +: 2]     = s.delay_select;
    ctrl_word[POWER_DOWN_BIT]     = s.detector_power_down;
    ctrl_word[RECOV_EN_BIT]       = s.recovery_irq_enable;
    ctrl_word[DROOP_EN_BIT]       = s.droop_irq_enable;
  endfunction

  function automatic logic [31:0] flags_word(input mon_state_s s);
    flags_word                    = 32'h0000_0000;
    flags_word[DROOP_FLAG_BIT]    = s.droop_flag;
    flags_word[RECOV_FLAG_BIT]    = s.recovery_flag;
  endfunction

  logic               access;
  logic               wr_ctrl;
  logic               wr_flags;
  logic               below;
  logic               above;
  logic               set_droop;
  logic               set_recov;
  logic               clr_droop;
  logic               clr_recov;
  logic [COUNT_W-1:0] target;

  always_comb
  begin
    st_next   = st_reg;
    set_droop = 1'b0;
    set_recov = 1'b0;

    // Bus slave: one wait state, ack dropped after one cycle
    access   = WB_REQ.cyc && WB_REQ.stb && !st_reg.ack;
    wr_ctrl  = access && WB_REQ.we && WB_REQ.sel[0] && (WB_REQ.adr == CTRL_OFS);
    wr_flags = access && WB_REQ.we && WB_REQ.sel[0] && (WB_REQ.adr == FLAGS_OFS);
    st_next.ack   = access;
    st_next.rdata = 32'h0000_0000;
    if (access && !WB_REQ.we)
    begin
      if (WB_REQ.adr == CTRL_OFS)
      begin
        st_next.rdata = ctrl_word(st_reg);
      end
      else if (WB_REQ.adr == FLAGS_OFS)
      begin
        st_next.rdata = flags_word(st_reg);
      end
    end

    if (wr_ctrl)
    begin
      st_next.threshold_select    = WB_REQ.dat[THRESH_LSB +: 3];
      st_next.delay_select        = WB_REQ.dat[DELAY_LSB +: 2];
      st_next.detector_power_down = WB_REQ.dat[POWER_DOWN_BIT];
      st_next.recovery_irq_enable = WB_REQ.dat[RECOV_EN_BIT];
      st_next.droop_irq_enable    = WB_REQ.dat[DROOP_EN_BIT];
    end

    // Asynchronous comparators: first stage feeds only the second
    st_next.sync1 = {CMP_ABOVE, CMP_BELOW};
    st_next.sync2 = st_reg.sync1;
    below         = st_reg.sync2[0];
    above         = st_reg.sync2[1];
    target        = qual_cycles(st_reg.threshold_select, st_reg.delay_select);

    case (st_reg.state)
      ST_OFF:
      begin
        st_next.count = '0;
        if (!st_reg.detector_power_down)
        begin
          st_next.state = ST_WATCH;
        end
      end
      ST_WATCH:
      begin
        // Any gap in the indication restarts the qualification
        if (!below)
        begin
          st_next.count = '0;
        end
        else if (st_reg.count >= target - COUNT_W'(1))
        begin
          st_next.count = '0;
          st_next.state = ST_LOW;
          set_droop     = 1'b1;
        end
        else
        begin
          st_next.count = st_reg.count + COUNT_W'(1);
        end
      end
      ST_LOW:
      begin
        // Recovery qualified with the same delay to reject ripple
        if (!above)
        begin
          st_next.count = '0;
        end
        else if (st_reg.count >= target - COUNT_W'(1))
        begin
          st_next.count = '0;
          st_next.state = ST_WATCH;
          set_recov     = 1'b1;
        end
        else
        begin
          st_next.count = st_reg.count + COUNT_W'(1);
        end
      end
      default:
      begin
        st_next.state = ST_OFF;
        st_next.count = '0;
      end
    endcase

    if (st_reg.detector_power_down)
    begin
      st_next.state = ST_OFF;
      st_next.count = '0;
      set_droop     = 1'b0;
      set_recov     = 1'b0;
    end

    // New event beats a simultaneous clear
    clr_droop = wr_flags && WB_REQ.dat[DROOP_FLAG_BIT];
    clr_recov = wr_flags && WB_REQ.dat[RECOV_FLAG_BIT];
    st_next.droop_flag    = (st_reg.droop_flag && !clr_droop) || set_droop;
    st_next.recovery_flag = (st_reg.recovery_flag && !clr_recov) || set_recov;

    st_next.irq = (st_next.droop_flag && st_next.droop_irq_enable)
               || (st_next.recovery_flag && st_next.recovery_irq_enable);
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_reg <= STATE_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign WB_RSP.ack                = st_reg.ack;
  assign WB_RSP.dat                = st_reg.rdata;
  assign ANA_CTRL.power_down       = st_reg.detector_power_down;
  assign ANA_CTRL.threshold_select = st_reg.threshold_select;
  assign IRQ                       = st_reg.irq;

endmodule // supply_voltage_monitor

// *** verif/monitor_checker.sv ***
// Port-level assertions for the supply voltage monitor
`timescale 1ns/1ps
module monitor_checker
  import supply_monitor_pkg::*;
(
  input wire logic                             CORE_CLK,
  input wire logic                             RESETN,
  input wire supply_monitor_pkg::wb_req_s      WB_REQ,
  input wire supply_monitor_pkg::wb_rsp_s      WB_RSP,
  input wire supply_monitor_pkg::analog_ctrl_s ANA_CTRL,
  input wire logic                             IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  wire take = WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
  wire wr = take && WB_REQ.we;
  wire ctl_wr = wr && WB_REQ.adr == CTRL_OFS;
  ack_latency_a: assert property (take |=> WB_RSP.ack) else $error("ack late");
  ack_pulse_a: assert property (WB_RSP.ack |=> !WB_RSP.ack) else $error("ack held");
  ack_cause_a: assert property ($rose(WB_RSP.ack) |-> $past(take)) else $error("stray ack");
  data_idle_a: assert property (!WB_RSP.ack |-> WB_RSP.dat == '0) else $error("dat idle");
  ctrl_write_a: assert property (ctl_wr && WB_REQ.sel[0] |=>
    ANA_CTRL == {$past(WB_REQ.dat[2]), $past(WB_REQ.dat[7:5])}) else $error("ctrl out");
  ctrl_stable_a: assert property ($changed(ANA_CTRL) |-> $past(ctl_wr)) else $error("ctrl");
  irq_fall_a: assert property ($fell(IRQ) |-> $past(wr)) else $error("irq dropped");
  // Two sampled cycles off, so no qualification can still be in flight
  off_quiet_a: assert property (ANA_CTRL.power_down && $past(ANA_CTRL.power_down) && !IRQ
    && !wr |=> !IRQ) else $error("irq while off");
endmodule // monitor_checker
bind supply_voltage_monitor monitor_checker monitor_checker_i (.CORE_CLK(CORE_CLK),
  .RESETN(RESETN), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP), .ANA_CTRL(ANA_CTRL), .IRQ(IRQ));

// *** verif/comparator_model.sv ***
// Behavioural supply comparator front end
`timescale 1ns/1ps
module comparator_model
  import supply_monitor_pkg::*;
(
  input  wire logic [12:0]                      mv,
  input  wire supply_monitor_pkg::analog_ctrl_s ctrl,
  output logic                                  below,
  output logic                                  above
);
  logic [12:0] trip;
  assign trip = 13'h960 + 13'(ctrl.threshold_select) * 13'h12C;
  // Unpowered detector reports nothing either way
  assign below = !ctrl.power_down && mv <= trip;
  assign above = !ctrl.power_down && mv >= trip + 13'h64;
endmodule // comparator_model

// *** verif/supply_voltage_monitor_test.sv ***
// Random and corner-case bench for the supply voltage monitor
`timescale 1ns/1ps
module supply_voltage_monitor_test;
  import supply_monitor_pkg::*;
  localparam int US = 2;
  logic         CORE_CLK = 1'h0;
  logic         RESETN = 1'h0;
  wb_req_s      req = '0;
  wb_rsp_s      rsp;
  analog_ctrl_s ana;
  logic         below, above, irq;
  logic [12:0]  mv = 13'h1388;
  logic [31:0]  seed = 32'h1_0FDC;
  int           fail_count = 0;
  int           comparisons = 0;
  always #2.5 CORE_CLK = ~CORE_CLK;
  supply_voltage_monitor #(.US_CYCLES(US)) supply_voltage_monitor_i (.CORE_CLK(CORE_CLK),
    .RESETN(RESETN), .WB_REQ(req), .WB_RSP(rsp), .CMP_BELOW(below), .CMP_ABOVE(above),
    .ANA_CTRL(ana), .IRQ(irq));
  comparator_model comparator_model_i (.mv(mv), .ctrl(ana), .below(below), .above(above));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reads compare against d; request held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    req <= '{1'h1, 1'h1, w, a, 4'hF, d};
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (rsp.ack !== 1'h1 && n < 40);
    if (rsp.ack !== 1'h1)
    begin
      fail_count++;
      close_out();
    end
    if (!w)
      chk(rsp.dat, d);
    req <= '0;
    @(posedge CORE_CLK);
  endtask
  task automatic hold(input logic [12:0] v, input int c);
    mv <= v;
    repeat (c) @(posedge CORE_CLK);
  endtask
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    fail_count++;
    close_out();
  end
  initial
  begin
    repeat (5) @(posedge CORE_CLK);
    RESETN <= 1'h1;
    @(posedge CORE_CLK);
    wb(1'h0, CTRL_OFS, CTRL_RESET);
    wb(1'h0, FLAGS_OFS, FLAGS_RESET);
    wb(1'h1, 8'h24, 32'hFF);
    wb(1'h0, CTRL_OFS, CTRL_RESET);
    $display("reset test done");
    for (int th = 1; th < 8; th++)
    begin
      logic [31:0] ctrl;
      logic [12:0] trip;
      int n;
      ctrl = {24'h0, th[2:0], 2'(th), 1'h1, 2'(rnd())};
      n = QUAL_US[th][ctrl[4:3]] * US;
      trip = 13'h960 + 13'(th) * 13'h12C;
      hold(13'h1388, 1);
      wb(1'h1, CTRL_OFS, ctrl);
      chk(32'(ana), {28'h0, 1'h1, th[2:0]});
      wb(1'h1, FLAGS_OFS, 32'h3);
      ctrl[2] = 1'h0;
      wb(1'h1, CTRL_OFS, ctrl);
      wb(1'h0, CTRL_OFS, ctrl);
      hold(trip - 13'(rnd() % 32'hC8), n - 2);
      hold(trip + 13'hC8, 8);
      wb(1'h0, FLAGS_OFS, 32'h0);
      hold(trip, n + 6);
      hold(trip + 13'h1 + 13'(rnd() % 32'h63), n + 6);
      wb(1'h0, FLAGS_OFS, 32'h1);
      chk(32'(irq), 32'(ctrl[0]));
      hold(trip + 13'hC8, n + 6);
      wb(1'h0, FLAGS_OFS, 32'h3);
      chk(32'(irq), 32'(|ctrl[1:0]));
      wb(1'h1, FLAGS_OFS, 32'h0);
      wb(1'h1, FLAGS_OFS, 32'h1);
      wb(1'h0, FLAGS_OFS, 32'h2);
      chk(32'(irq), 32'(ctrl[1]));
      wb(1'h1, FLAGS_OFS, 32'h2);
      wb(1'h0, FLAGS_OFS, 32'h0);
      $display("threshold %0d test done", th);
    end
    wb(1'h1, CTRL_OFS, 32'h27);
    chk(32'(ana), 32'h9);
    hold(13'h0, 400);
    wb(1'h0, FLAGS_OFS, 32'h0);
    $display("power down test done");
    close_out();
  end
endmodule // supply_voltage_monitor_test
